// ### scr_cal_store.v
/*
 * Four-word calibration store; read data comes out of a register.
 * Assumes a single clock and an asynchronous active-high reset.
 */
`timescale 1ns/1ps
`default_nettype none
`include "scr_regs.vh"

module scr_cal_store (
    input wire clk,
    input wire rst,
    input wire [1:0] rd_index,
    input wire [15:0] word_one,
    input wire [15:0] word_two,
    input wire [15:0] word_three,
    input wire [15:0] word_four,
    output reg [15:0] rd_data_q
);
    reg [15:0] rd_data_d;

    // ****************************************
    // word select
    // ****************************************
    always @* begin
        case (rd_index)
            `SCR_CAL_WORD_ONE: rd_data_d = word_one;
            `SCR_CAL_WORD_TWO: rd_data_d = word_two;
            `SCR_CAL_WORD_THREE: rd_data_d = word_three;
            default: rd_data_d = word_four;
        endcase
    end

    // registered read data
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            rd_data_q <= 16'h0000;
        end else begin
            rd_data_q <= rd_data_d;
        end
    end
endmodule // scr_cal_store

`default_nettype wire

// ### scr_host_model.sv
/* host side of the three-wire link: drives clock and data, samples replies.
   assumes the device takes and answers bits on the link clock rise. */
`timescale 1ns/1ps
`default_nettype none
// ****************
// host link driver
// ****************
module scr_host_model (
    output logic sclk,
    output logic sdin,
    input wire logic sdout
);
    // link clock stands low between frames
    initial begin
        sclk = 1'b0;
        sdin = 1'b0;
    end
    // n bits msb first, changed after fall, reply sampled on fall
    task automatic xfer(input int n, input logic [20:0] v, output logic [16:0] r);
        r = '0;
        for (int i = n - 1; i >= 0; i--) begin
            sdin = v[i];
            #62.5 sclk = 1'b1;
            #62.5 sclk = 1'b0;
            r = {r[15:0], sdout};
        end
    endtask
endmodule // scr_host_model
`default_nettype wire

// ### scr_regs.vh
/*
 * Constants for the sensor calibration readout block: calibration word
 * indices, coefficient field positions, link command codes and timing.
 * Assumes it is included by bare name from the block's design files.
 */
`ifndef SCR_REGS_VH
`define SCR_REGS_VH

// calibration word indices into the four-word store
`define SCR_CAL_WORD_ONE 2'h0
`define SCR_CAL_WORD_TWO 2'h1
`define SCR_CAL_WORD_THREE 2'h2
`define SCR_CAL_WORD_FOUR 2'h3

// coefficient field positions inside the calibration words
`define SCR_W1_COEFF_ONE_LSB 3
`define SCR_W2_COEFF_TWO_LSB 6
`define SCR_W3_COEFF_THREE_LSB 6
`define SCR_W4_COEFF_FOUR_LSB 7

// reset values of the calibration words (factory content stands in)
`define SCR_CAL_WORD_ONE_RST 16'h0000
`define SCR_CAL_WORD_TWO_RST 16'h0000
`define SCR_CAL_WORD_THREE_RST 16'h0000
`define SCR_CAL_WORD_FOUR_RST 16'h0000

// four-bit setup codes received between start and stop
`define SCR_CMD_PRESSURE 4'hA
`define SCR_CMD_TEMPERATURE 4'h9
`define SCR_CMD_WORD_ONE 4'h5
`define SCR_CMD_WORD_TWO 4'h6
`define SCR_CMD_WORD_THREE 4'h3
`define SCR_CMD_WORD_FOUR 4'h4

// reset pattern: 21 link bits, 16 alternating then five zeros
`define SCR_RESET_PATTERN 21'h155540
`define SCR_RESET_LEN 21

// conversion time in microseconds, and clock period in picoseconds
`define SCR_TCONV_US 35000
`define SCR_CLK_PERIOD_PS 8000

`endif

// ### scr_sensor_readout.v
/*
 * Device side of the sensor readout: three-wire link slave, shared
 * converter sequencing, calibration word readout.
 * Assumes link clock and data-in are asynchronous pins sampled by clk,
 * and that the converter result is valid on adc_result when the conversion count ends.
 */
// What the document requires of this block and its host
// R1: deliver pressure and temperature as 16-bit values
// R2: one shared converter, one conversion at once
// R3: hold four 16-bit calibration words; host fetches all
// R4: host may read calibration once after reset
// R5: host unpacks words one and two fields
// R6: host unpacks words three and four fields
// R7: calibration words encode six coefficients, readable
// R8: host uses only masks and shifts
// R9: host polls pressure and temperature periodically
// R10: host arithmetic signed 16-bit, 32-bit products (bench multiplies 17-bit signed operands into a 33-bit prod)
// R11: host divisions are right shifts, below 65536
// R12: host may read temperature less often
// R13: host averages eight pressure results
// R14: acknowledge start high, end of conversion low
// R15: host clocks 17 pulses to read result
// R16: host reads result before next conversion
// R17: word four bit seven is coefficient four bit0
`timescale 1ns/1ps
`default_nettype none
`include "scr_regs.vh"

module scr_sensor_readout #(
    parameter CONV_CYCLES = (`SCR_TCONV_US * 1000) / (`SCR_CLK_PERIOD_PS / 1000),
    parameter [15:0] CAL_WORD_ONE = `SCR_CAL_WORD_ONE_RST,
    parameter [15:0] CAL_WORD_TWO = `SCR_CAL_WORD_TWO_RST,
    parameter [15:0] CAL_WORD_THREE = `SCR_CAL_WORD_THREE_RST,
    parameter [15:0] CAL_WORD_FOUR = `SCR_CAL_WORD_FOUR_RST
) (
    input wire clk,
    input wire rst,
    input wire serial_clock_in,
    input wire serial_data_in,
    output reg serial_output_line_q,
    output reg conv_busy_q,
    output reg conv_is_temp_q,
    input wire [15:0] adc_result,
    output reg [15:0] pressure_raw_value_q,
    output reg [15:0] temperature_raw_value_q
);
    localparam ST_IDLE = 3'h0;
    localparam ST_ACK = 3'h1;
    localparam ST_CONV = 3'h2;
    localparam ST_SHIFT = 3'h3;
    localparam ST_STOP = 3'h4;
    // store output register already holds the newly selected word here
    localparam ST_LOAD = 3'h5;

    reg [2:0] sck_sync_q;
    reg [2:0] sdi_sync_q;
    reg sck_level_q;
    reg sdi_level_q;
    reg [2:0] state_q;
    reg [20:0] hist_q;
    reg [4:0] bit_cnt_q;
    reg [16:0] shift_q;
    reg [31:0] conv_cnt_q;
    reg [1:0] word_sel_q;
    wire [15:0] cal_word;
    wire sck_rise;
    wire sck_fall;
    wire [20:0] hist_next;

    // ****************************************
    // pin synchronisers
    // ****************************************
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            sck_sync_q <= 3'h0;
            sdi_sync_q <= 3'h0;
            sck_level_q <= 1'b0;
            sdi_level_q <= 1'b0;
        end else begin
            sck_sync_q <= {sck_sync_q[1:0], serial_clock_in};
            sdi_sync_q <= {sdi_sync_q[1:0], serial_data_in};
            if (sck_sync_q[1] == sck_sync_q[2]) begin
                sck_level_q <= sck_sync_q[2];
            end
            if (sdi_sync_q[1] == sdi_sync_q[2]) begin
                sdi_level_q <= sdi_sync_q[2];
            end
        end
    end

    // link clock edges from the filtered level
    assign sck_rise = (sck_sync_q[1] == sck_sync_q[2]) && sck_sync_q[2] && !sck_level_q;
    assign sck_fall = (sck_sync_q[1] == sck_sync_q[2]) && !sck_sync_q[2] && sck_level_q;
    assign hist_next = {hist_q[19:0], sdi_level_q};

    // ****************************************
    // calibration store
    // ****************************************
    scr_cal_store u_store (
        .clk(clk),
        .rst(rst),
        .rd_index(word_sel_q),
        .word_one(CAL_WORD_ONE), // R7
        .word_two(CAL_WORD_TWO),
        .word_three(CAL_WORD_THREE),
        .word_four(CAL_WORD_FOUR), // R17
        .rd_data_q(cal_word)
    );

    // ****************************************
    // link protocol and conversion sequencing
    // ****************************************
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            state_q <= ST_IDLE;
            hist_q <= 21'h000000;
            bit_cnt_q <= 5'h00;
            shift_q <= 17'h00000;
            conv_cnt_q <= 32'h00000000;
            word_sel_q <= 2'h0;
            serial_output_line_q <= 1'b0;
            conv_busy_q <= 1'b0;
            conv_is_temp_q <= 1'b0;
            pressure_raw_value_q <= 16'h0000;
            temperature_raw_value_q <= 16'h0000;
        end else if (sck_rise && hist_next == `SCR_RESET_PATTERN) begin
            // reset pattern recognised in any state
            state_q <= ST_IDLE;
            hist_q <= 21'h000000;
            bit_cnt_q <= 5'h00;
            serial_output_line_q <= 1'b0;
            conv_busy_q <= 1'b0;
        end else begin
            // history runs in every state so the reset pattern is seen anywhere
            // (command decode still only looks at it while idle)
            if (sck_rise) begin
                hist_q <= hist_next;
            end
            case (state_q)
                ST_IDLE: begin
                    if (sck_rise) begin
                        hist_q <= hist_next;
                        // start 111, setup 4 bits, stop 000
                        if (hist_next[9:0] == {3'h7, hist_next[6:3], 3'h0}) begin
                            hist_q <= 21'h000000;
                            case (hist_next[6:3])
                                `SCR_CMD_PRESSURE, `SCR_CMD_TEMPERATURE: begin
                                    // single converter: one conversion at once
                                    conv_busy_q <= 1'b1; // R2
                                    conv_is_temp_q <= (hist_next[6:3] == `SCR_CMD_TEMPERATURE);
                                    serial_output_line_q <= 1'b1; // R14
                                    bit_cnt_q <= 5'h02;
                                    state_q <= ST_ACK;
                                end
                                `SCR_CMD_WORD_ONE, `SCR_CMD_WORD_TWO,
                                `SCR_CMD_WORD_THREE, `SCR_CMD_WORD_FOUR: begin
                                    word_sel_q <= (hist_next[6:3] == `SCR_CMD_WORD_ONE) ? `SCR_CAL_WORD_ONE :
                                        (hist_next[6:3] == `SCR_CMD_WORD_TWO) ? `SCR_CAL_WORD_TWO :
                                        (hist_next[6:3] == `SCR_CMD_WORD_THREE) ? `SCR_CAL_WORD_THREE :
                                        `SCR_CAL_WORD_FOUR; // R3
                                    bit_cnt_q <= 5'h11;
                                    state_q <= ST_STOP;
                                end
                                default: state_q <= ST_IDLE;
                            endcase
                        end
                    end
                end
                ST_STOP: begin
                    // new index reaches the store output register this cycle
                    state_q <= ST_LOAD;
                end
                ST_LOAD: begin
                    // store output now holds the selected word: load the shifter
                    shift_q <= {1'b0, cal_word};
                    serial_output_line_q <= 1'b0;
                    state_q <= ST_SHIFT;
                end
                ST_ACK: begin
                    // two more link clocks after the acknowledge
                    if (sck_rise) begin
                        bit_cnt_q <= bit_cnt_q - 5'h01;
                        if (bit_cnt_q == 5'h01) begin
                            conv_cnt_q <= 32'h00000000;
                            state_q <= ST_CONV;
                        end
                    end
                end
                ST_CONV: begin
                    conv_cnt_q <= conv_cnt_q + 32'h00000001;
                    if (conv_cnt_q >= CONV_CYCLES - 1) begin
                        // end of conversion: latch result, drop the line, start readout
                        if (conv_is_temp_q) begin
                            temperature_raw_value_q <= adc_result; // R1
                        end else begin
                            pressure_raw_value_q <= adc_result; // R1
                        end
                        conv_busy_q <= 1'b0;
                        serial_output_line_q <= 1'b0; // R14
                        shift_q <= {1'b0, adc_result};
                        bit_cnt_q <= 5'h11;
                        state_q <= ST_SHIFT;
                    end
                end
                ST_SHIFT: begin
                    // 17 clocks: data bits go out on rising edges, msb first
                    if (sck_rise) begin
                        serial_output_line_q <= shift_q[15];
                        shift_q <= {shift_q[15:0], 1'b0};
                        bit_cnt_q <= bit_cnt_q - 5'h01;
                    end
                    if (sck_fall && bit_cnt_q == 5'h00) begin
                        serial_output_line_q <= 1'b0;
                        state_q <= ST_IDLE;
                    end
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end
endmodule // scr_sensor_readout

`default_nettype wire

// ### scr_sensor_readout_bench.sv
/* self-checking bench for the sensor readout with a host link model.
   assumes the design and host model are compiled before it. */
`timescale 1ns/1ps
`default_nettype none
`include "scr_regs.vh"
`define SCR_CHK(a, b) begin checks_done++; if ((a) !== (b)) begin errors++; \
    $display("Error at %0t: got %h expected %h", $time, a, b); end end
// ***********
// bench top
// ***********
module scr_sensor_readout_bench;
    localparam logic [15:0] W[4] = '{16'hA5C3, 16'h3E59, 16'hC78A, 16'h5B26};
    localparam logic [3:0] WCMD[4] = '{`SCR_CMD_WORD_ONE, `SCR_CMD_WORD_TWO, `SCR_CMD_WORD_THREE, `SCR_CMD_WORD_FOUR};
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [15:0] adc_result = 16'h0000;
    logic [15:0] lfsr_q = 16'h25B5;
    logic [15:0] exp_q[$];
    wire sclk, sdin, sdout, busy, is_temp;
    wire [15:0] p_raw, t_raw;
    int errors = 0;
    int checks_done = 0;
    logic [15:0] rd_w[4];
    logic [15:0] cf[6];
    logic signed [32:0] prod;
    logic [18:0] sum_rd;
    logic [18:0] sum_mod;
    logic [15:0] last_t;
    // system clock, 8 ns
    always #4 clk = ~clk;
    scr_host_model u_scr_host_model (.sclk(sclk), .sdin(sdin), .sdout(sdout));
    scr_sensor_readout #(.CONV_CYCLES(50), .CAL_WORD_ONE(W[0]), .CAL_WORD_TWO(W[1]), .CAL_WORD_THREE(W[2]),
        .CAL_WORD_FOUR(W[3])) u_scr_sensor_readout (.clk(clk), .rst(rst), .serial_clock_in(sclk),
        .serial_data_in(sdin), .serial_output_line_q(sdout), .conv_busy_q(busy), .conv_is_temp_q(is_temp),
        .adc_result(adc_result), .pressure_raw_value_q(p_raw), .temperature_raw_value_q(t_raw));
    function automatic logic [15:0] lfsr_next(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    task automatic print_verdict();
        $display("errors %0d checks %0d", errors, checks_done);
        if (errors == 0 && checks_done > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    // bounded wait for the link output level
    task automatic wait_line(input logic lvl);
        int n;
        n = 0;
        while (sdout !== lvl) begin
            @(posedge clk);
            n++;
            if (n > 2000) begin errors++; print_verdict(); end
        end
    endtask
    // link reset pattern, then start, setup code and stop
    task automatic cmd(input logic [3:0] c);
        logic [16:0] r;
        u_scr_host_model.xfer(21, `SCR_RESET_PATTERN, r);
        u_scr_host_model.xfer(10, {11'h000, 3'b111, c, 3'b000}, r);
    endtask
    // one conversion with a random converter value, read out in full
    task automatic conv(input logic [3:0] c, input logic temp);
        logic [16:0] r;
        longint m;
        @(posedge clk);
        adc_result <= lfsr_q;
        exp_q.push_back(lfsr_q);
        lfsr_q = lfsr_next(lfsr_q);
        cmd(c);
        repeat (8) @(posedge clk);
        `SCR_CHK(sdout, 1'b1)
        `SCR_CHK(busy, 1'b1)
        u_scr_host_model.xfer(2, 21'h000000, r);
        wait_line(1'b0);
        u_scr_host_model.xfer(17, 21'h000000, r);
        `SCR_CHK(r[16:1], exp_q[0])
        `SCR_CHK(r[0], 1'b0)
        `SCR_CHK(is_temp, temp)
        // host scaling: signed product, then a shift in place of the division
        prod = $signed({1'b0, cf[0]}) * $signed({1'b0, r[16:1]});
        m = W[0][15:3];
        m = (m * exp_q[0]) >> 16;
        `SCR_CHK(prod >>> 16, m)
        `SCR_CHK((prod >>> 16) < 65536, 1'b1)
        if (temp) begin
            last_t = exp_q[0];
        end else begin
            sum_rd = sum_rd + r[16:1];
            sum_mod = sum_mod + exp_q[0];
        end
        `SCR_CHK(temp ? t_raw : p_raw, exp_q.pop_front())
    endtask
    // main sequence
    initial begin
        logic [16:0] r;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        repeat (4) @(posedge clk);
        // all four calibration words, once after reset
        for (int i = 0; i < 4; i++) begin
            cmd(WCMD[i]);
            u_scr_host_model.xfer(17, 21'h000000, r);
            rd_w[i] = r[16:1];
            `SCR_CHK(r[16:1], W[i])
        end
        // host unpacks the coefficients with masks and shifts only
        cf[0] = (rd_w[0] >> 3) & 16'h1FFF;
        cf[1] = ((rd_w[0] & 16'h0007) << 10) | (rd_w[1] >> 6);
        cf[2] = rd_w[2] >> 6;
        cf[3] = rd_w[3] >> 7;
        cf[4] = ((rd_w[1] & 16'h003F) << 6) | (rd_w[2] & 16'h003F);
        cf[5] = rd_w[3] & 16'h007F;
        `SCR_CHK(cf[0], {3'h0, W[0][15:3]})
        `SCR_CHK(cf[1], {3'h0, W[0][2:0], W[1][15:6]})
        `SCR_CHK(cf[2], {6'h00, W[2][15:6]})
        `SCR_CHK(cf[3], {7'h00, W[3][15:7]})
        `SCR_CHK(cf[4], {4'h0, W[1][5:0], W[2][5:0]})
        `SCR_CHK(cf[5], {9'h000, W[3][6:0]})
        sum_rd = 19'h00000;
        sum_mod = 19'h00000;
        cmd(4'h0);
        repeat (40) @(posedge clk);
        `SCR_CHK(busy, 1'b0)
        // periodic pressure and temperature polling
        for (int i = 0; i < 4; i++) conv(i[0] ? `SCR_CMD_TEMPERATURE : `SCR_CMD_PRESSURE, i[0]);
        // eight pressures in a row, temperature left alone, then averaged
        sum_rd = 19'h00000;
        sum_mod = 19'h00000;
        for (int i = 0; i < 8; i++) conv(`SCR_CMD_PRESSURE, 1'b0);
        `SCR_CHK(sum_rd >> 3, sum_mod >> 3)
        `SCR_CHK(t_raw, last_t)
        print_verdict();
    end
endmodule // scr_sensor_readout_bench
`default_nettype wire

// ### scr_sensor_readout_chk.sv
/* checker for the sensor readout: conversion and result relations.
   assumes it is bound to the readout top module. */
`timescale 1ns/1ps
`default_nettype none
// *************
// port checker
// *************
module scr_sensor_readout_chk #(parameter CONV_CYCLES = 50) (
    input wire logic clk,
    input wire logic rst,
    input wire logic serial_output_line_q,
    input wire logic conv_busy_q,
    input wire logic conv_is_temp_q,
    input wire logic [15:0] adc_result,
    input wire logic [15:0] pressure_raw_value_q,
    input wire logic [15:0] temperature_raw_value_q
);
    logic [31:0] busy_n_q;
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    // counts cycles of the running conversion
    always @(posedge clk or posedge rst) begin
        if (rst) busy_n_q <= 32'h0;
        else busy_n_q <= conv_busy_q ? busy_n_q + 32'h1 : 32'h0;
    end
    busy_min_a: assert property ($fell(conv_busy_q) |-> busy_n_q >= CONV_CYCLES)
        else $error("conversion ended early");
    kind_stable_a: assert property (conv_busy_q && $past(conv_busy_q) |-> $stable(conv_is_temp_q))
        else $error("kind changed in conversion");
    line_busy_a: assert property (conv_busy_q && $past(conv_busy_q) |-> serial_output_line_q)
        else $error("line low while converting");
    line_end_a: assert property ($fell(conv_busy_q) |-> ##[0:1] !serial_output_line_q)
        else $error("line not low at end");
    press_end_a: assert property ($changed(pressure_raw_value_q) |-> $fell(serial_output_line_q)
        && !conv_is_temp_q && $stable(temperature_raw_value_q))
        else $error("pressure result off end");
    temp_end_a: assert property ($changed(temperature_raw_value_q) |-> $fell(serial_output_line_q)
        && conv_is_temp_q)
        else $error("temperature result off end");
    press_data_a: assert property ($changed(pressure_raw_value_q) |-> pressure_raw_value_q == $past(adc_result))
        else $error("pressure result wrong");
    temp_data_a: assert property ($changed(temperature_raw_value_q) |->
        temperature_raw_value_q == $past(adc_result))
        else $error("temperature result wrong");
    press_c: cover property ($fell(conv_busy_q) && !conv_is_temp_q);
    temp_c: cover property ($fell(conv_busy_q) && conv_is_temp_q);
    ack_c: cover property ($rose(serial_output_line_q) && conv_busy_q);
endmodule // scr_sensor_readout_chk
bind scr_sensor_readout scr_sensor_readout_chk #(.CONV_CYCLES(CONV_CYCLES)) u_scr_sensor_readout_chk (
    .clk(clk), .rst(rst), .serial_output_line_q(serial_output_line_q), .conv_busy_q(conv_busy_q),
    .conv_is_temp_q(conv_is_temp_q), .adc_result(adc_result), .pressure_raw_value_q(pressure_raw_value_q),
    .temperature_raw_value_q(temperature_raw_value_q));
`default_nettype wire
